// ===== logic/tcc_noise_filter.sv
// Capture input sampler, four-sample noise canceler and edge detector.
`timescale 1ns/100ps
`include "tcc_consts.svh"
module tcc_noise_filter (
  // System clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Link to the timer core.
  tcc_cap_if.filt cif
);
  logic in_q;                               // Sampled trigger level.
  logic [`TCC_FILT_SAMPLES-1:0] hist;       // Last four samples.
  logic filt_out;                           // Filtered level.
  logic filt_prev;                          // Filtered level one cycle back.

  // Sample the source and keep a short history; runs on the system clock only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_q <= 1'b0;
      hist <= '0;
    end else begin
      in_q <= cif.raw_in;
      hist <= {hist[`TCC_FILT_SAMPLES-2:0], in_q}; // see [R20]
    end
  end

  // The output only moves once every sample agrees; bypassed when disabled.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_out <= 1'b0;
    end else if (!cif.filt_en) begin
      filt_out <= in_q;
    end else if (&hist) begin
      filt_out <= 1'b1; // see [R19]
    end else if (~|hist) begin
      filt_out <= 1'b0; // see [R19]
    end
  end

  // Edge detector; the previous level keeps tracking while disabled so that
  // re-enabling does not see a stale edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_prev <= 1'b0;
      cif.cap_evt <= 1'b0;
    end else begin
      filt_prev <= filt_out;
      cif.cap_evt <= cif.input_en && (cif.rising_sel ? (filt_out && !filt_prev)
                                                     : (!filt_out && filt_prev)); // see [R24]
    end
  end

  a_filter_hold: assert property (@(posedge clk) disable iff (!rstn) // see [R19]
    cif.filt_en && (|hist) && !(&hist) |=> filt_out == $past(filt_out))
    else $error("Filter output moved while samples disagreed.");

  a_edge_gate: assert property (@(posedge clk) disable iff (!rstn) // see [R21]
    !cif.input_en |=> !cif.cap_evt)
    else $error("Capture strobe raised while the input was disabled.");
endmodule

// ===== logic/tcc_timer16.sv
// Sixteen-bit timer/counter core with shared prescaler and input capture.
`timescale 1ns/100ps
`include "tcc_consts.svh"

// Function
// [R1] Clock select zero keeps counter stopped.
// [R2] Prescaled first count lands 1 to N+1 cycles.
// [R3] Free-running shared prescaler; reset restarts all periods.
// [R4] Tick counts up, down or clears; flags extremes.
// [R5] Low-byte read latches high byte for later.
// [R6] High write fills hold; low write loads all.
// [R7] CPU write beats any count action.
// [R8] Counter accessible with or without a tick.
// [R9] Four-bit waveform mode picks the sequence.
// [R10] Overflow flag set per mode, can interrupt.
// [R11] Matching edge copies counter into capture register.
// [R12] Capture flag sets in the copy cycle.
// [R13] Capture flag interrupts; cleared by ack or one.
// [R14] Capture low read latches high byte first.
// [R15] Capture register writable only in ceiling modes.
// [R16] Software writes high byte before low byte.
// [R17] Comparator capture select swaps in comparator output.
// [R18] Source switch may capture; software clears flag.
// [R19] Filter output changes after four agreeing samples.
// [R20] Filter enabled by bit, system clock, four-cycle delay.
// [R21] Capture input off only in capture-ceiling modes.
// [R22] Driving the capture pin port triggers capture.
// [R23] Ceiling is fixed, compare A or capture register.
// [R24] Edge setting picks rising or falling trigger.
module tcc_timer16 (
  // System clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Byte-wide CPU access port.
  input wire tcc_pkg::tcc_sel_e acc_sel,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  // Control bits.
  input wire logic [2:0] clock_select_field,
  input wire logic [3:0] waveform_mode_field,
  input wire logic prescaler_reset,
  input wire logic noise_filter_enable,
  input wire logic edge_rising,
  input wire logic comparator_capture_select,
  input wire logic capture_irq_enable,
  input wire logic overflow_irq_enable,
  // Flag clearing: interrupt taken or a one written.
  input wire logic capture_irq_ack,
  input wire logic capture_flag_clear,
  input wire logic overflow_irq_ack,
  input wire logic overflow_flag_clear,
  // External event and count inputs.
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic ext_count_pin,
  // Status outputs.
  output logic [15:0] count_value,
  output logic count_ceiling,
  output logic count_floor,
  output logic capture_flag,
  output logic capture_irq,
  output logic overflow_flag,
  output logic overflow_irq,
  // Prescaler taps shared with the neighbouring timer.
  output logic [3:0] presc_taps
);
  import tcc_pkg::*;

  logic [9:0] presc;          // Free-running prescaler count.
  logic [3:0] tap_now;        // Divide-by-8, 64, 256 and 1024 pulses.
  logic ext_q;                // Sampled external count pin.
  logic ext_prev;             // External pin one cycle back.
  logic timer_tick;           // Selected count enable.
  tcc_seq_e seq;              // Sequence picked by the mode.
  logic [15:0] ceil_val;      // Current counter ceiling.
  logic cap_top;              // Capture register acts as ceiling.
  tcc_dir_e dir;              // Dual-slope direction.
  tcc_dir_e next_dir;         // Direction after this tick.
  logic [15:0] next_cnt;      // Counter after this tick.
  logic ovf_evt;              // Overflow point reached on this tick.
  logic [7:0] hold_byte;      // Shared high-byte holding register.
  logic [15:0] cap_reg;       // Capture register.
  logic [15:0] cmpa;          // Compare register A.
  logic wr_cnt_lo;            // CPU writes the counter.
  logic next_cap_flag;        // Capture flag for the next cycle.
  logic next_ovf_flag;        // Overflow flag for the next cycle.

  tcc_cap_if cif ();

  // Prescaler never looks at the clock select; its reset hits all users.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc <= `TCC_PRESC_RST;
    end else if (prescaler_reset) begin
      presc <= `TCC_PRESC_RST; // see [R3]
    end else begin
      presc <= presc + `TCC_PRESC_STEP; // see [R3]
    end
  end

  // Decode the taps; a fresh enable lands anywhere in the period.
  always_comb begin
    tap_now[0] = (presc & `TCC_MASK_DIV8) == `TCC_MASK_DIV8; // see [R2]
    tap_now[1] = (presc & `TCC_MASK_DIV64) == `TCC_MASK_DIV64;
    tap_now[2] = (presc & `TCC_MASK_DIV256) == `TCC_MASK_DIV256;
    tap_now[3] = (presc & `TCC_MASK_DIV1024) == `TCC_MASK_DIV1024;
  end

  // Registered copy of the taps for the neighbouring timer.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_taps <= 4'h0;
    end else begin
      presc_taps <= tap_now; // see [R3]
    end
  end

  // External count pin sampling for edge counting.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_q <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_q <= ext_count_pin;
      ext_prev <= ext_q;
    end
  end

  // Clock select picks the tick source; zero picks nothing.
  always_comb begin
    case (clock_select_field)
      `TCC_CS_STOP: timer_tick = 1'b0; // see [R1]
      `TCC_CS_DIV1: timer_tick = 1'b1;
      `TCC_CS_DIV8: timer_tick = tap_now[0]; // see [R2]
      `TCC_CS_DIV64: timer_tick = tap_now[1];
      `TCC_CS_DIV256: timer_tick = tap_now[2];
      `TCC_CS_DIV1024: timer_tick = tap_now[3];
      `TCC_CS_EXT_FALL: timer_tick = ext_prev && !ext_q;
      `TCC_CS_EXT_RISE: timer_tick = ext_q && !ext_prev;
      default: timer_tick = 1'b0;
    endcase
  end

  // Mode decode: sequence kind and ceiling source.
  always_comb begin
    seq = tcc_seq_normal;
    ceil_val = `TCC_MAX;
    case (waveform_mode_field) // see [R9]
      4'h1: begin seq = tcc_seq_dual; ceil_val = `TCC_TOP_8BIT; end // see [R23]
      4'h2: begin seq = tcc_seq_dual; ceil_val = `TCC_TOP_9BIT; end
      4'h3: begin seq = tcc_seq_dual; ceil_val = `TCC_TOP_10BIT; end
      4'h4: begin seq = tcc_seq_clear; ceil_val = cmpa; end
      4'h5: begin seq = tcc_seq_wrap; ceil_val = `TCC_TOP_8BIT; end
      4'h6: begin seq = tcc_seq_wrap; ceil_val = `TCC_TOP_9BIT; end
      4'h7: begin seq = tcc_seq_wrap; ceil_val = `TCC_TOP_10BIT; end
      4'h8: begin seq = tcc_seq_dual; ceil_val = cap_reg; end
      4'h9: begin seq = tcc_seq_dual; ceil_val = cmpa; end
      4'hA: begin seq = tcc_seq_dual; ceil_val = cap_reg; end
      4'hB: begin seq = tcc_seq_dual; ceil_val = cmpa; end
      4'hC: begin seq = tcc_seq_clear; ceil_val = cap_reg; end
      4'hE: begin seq = tcc_seq_wrap; ceil_val = cap_reg; end
      4'hF: begin seq = tcc_seq_wrap; ceil_val = cmpa; end
      default: begin seq = tcc_seq_normal; ceil_val = `TCC_MAX; end
    endcase
  end

  // Modes that use the capture register as the ceiling.
  assign cap_top = (waveform_mode_field == `TCC_WGM_PFC_CAP)
                || (waveform_mode_field == `TCC_WGM_PC_CAP)
                || (waveform_mode_field == `TCC_WGM_CTC_CAP)
                || (waveform_mode_field == `TCC_WGM_FAST_CAP);

  // Next counter value on a tick, and where the overflow point falls.
  always_comb begin
    next_cnt = count_value;
    next_dir = dir;
    ovf_evt = 1'b0;
    if (timer_tick) begin
      case (seq)
        tcc_seq_clear: begin
          // Clear at the ceiling; overflow only at the full-scale value.
          next_cnt = (count_value == ceil_val) ? `TCC_FLOOR
                                               : count_value + `TCC_CNT_STEP; // see [R4]
          ovf_evt = count_value == `TCC_MAX; // see [R10]
        end
        tcc_seq_wrap: begin
          // Wrap at the ceiling, which is also the overflow point.
          next_cnt = (count_value == ceil_val) ? `TCC_FLOOR
                                               : count_value + `TCC_CNT_STEP;
          ovf_evt = count_value == ceil_val; // see [R10]
        end
        tcc_seq_dual: begin
          // Turn around at the ceiling and at the floor.
          if (dir == tcc_dir_up) begin
            if (count_value >= ceil_val) begin
              next_dir = tcc_dir_down;
              next_cnt = count_value - `TCC_CNT_STEP; // see [R4]
            end else begin
              next_cnt = count_value + `TCC_CNT_STEP;
            end
          end else if (count_value == `TCC_FLOOR) begin
            next_dir = tcc_dir_up;
            next_cnt = count_value + `TCC_CNT_STEP;
            ovf_evt = 1'b1; // see [R10]
          end else begin
            next_cnt = count_value - `TCC_CNT_STEP;
          end
        end
        default: begin
          // Plain count through full scale.
          next_cnt = count_value + `TCC_CNT_STEP;
          ovf_evt = count_value == `TCC_MAX;
        end
      endcase
    end
  end

  assign wr_cnt_lo = acc_wr && (acc_sel == tcc_sel_cnt_lo);

  // Counter and direction; a CPU write overrides counting even when stopped.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_value <= `TCC_CNT_RST;
      dir <= tcc_dir_up;
    end else if (wr_cnt_lo) begin
      count_value <= {hold_byte, acc_wdata}; // see [R6] see [R7] see [R8]
    end else begin
      count_value <= next_cnt;
      dir <= next_dir;
    end
  end

  // Extremes registered, one cycle behind the counter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_ceiling <= 1'b0;
      count_floor <= 1'b0;
    end else begin
      count_ceiling <= count_value == ceil_val; // see [R4]
      count_floor <= count_value == `TCC_FLOOR;
    end
  end

  // Shared holding register: high-byte writes fill it, counter and capture low reads latch it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_byte <= `TCC_BYTE_RST;
    end else if (acc_wr && (acc_sel == tcc_sel_cnt_hi || acc_sel == tcc_sel_cap_hi
                            || acc_sel == tcc_sel_cmpa_hi)) begin
      hold_byte <= acc_wdata; // see [R6] see [R16]
    end else if (acc_rd && acc_sel == tcc_sel_cnt_lo) begin
      hold_byte <= count_value[15:8]; // see [R5]
    end else if (acc_rd && acc_sel == tcc_sel_cap_lo) begin
      hold_byte <= cap_reg[15:8]; // see [R14]
    end
  end

  // Read data; high locations of counter and capture return the hold byte.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_rdata <= `TCC_BYTE_RST;
    end else if (acc_rd) begin
      case (acc_sel)
        tcc_sel_cnt_lo: acc_rdata <= count_value[7:0]; // see [R8]
        tcc_sel_cnt_hi: acc_rdata <= hold_byte; // see [R5]
        tcc_sel_cap_lo: acc_rdata <= cap_reg[7:0];
        tcc_sel_cap_hi: acc_rdata <= hold_byte; // see [R14]
        tcc_sel_cmpa_lo: acc_rdata <= cmpa[7:0];
        tcc_sel_cmpa_hi: acc_rdata <= cmpa[15:8];
        default: acc_rdata <= `TCC_BYTE_RST;
      endcase
    end
  end

  // Compare register A, loaded whole on its low-byte write.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmpa <= `TCC_CNT_RST;
    end else if (acc_wr && acc_sel == tcc_sel_cmpa_lo) begin
      cmpa <= {hold_byte, acc_wdata};
    end
  end

  // Capture register: timestamps events, or takes a ceiling value in the
  // capture-ceiling modes, where the event input is shut off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_reg <= `TCC_CNT_RST;
    end else if (cif.cap_evt) begin
      cap_reg <= count_value; // see [R11]
    end else if (acc_wr && acc_sel == tcc_sel_cap_lo && cap_top) begin
      cap_reg <= {hold_byte, acc_wdata}; // see [R15]
    end
  end

  // Trigger path into the filter; the pin is sampled whoever drives it, so a
  // port write onto it triggers like any outside event.
  assign cif.raw_in = comparator_capture_select ? comparator_output // see [R17] see [R18]
                                                : capture_pin; // see [R22]
  assign cif.filt_en = noise_filter_enable; // see [R20]
  assign cif.rising_sel = edge_rising; // see [R24]
  assign cif.input_en = !cap_top; // see [R21]

  tcc_noise_filter u_filt (
    .clk(clk),
    .rstn(rstn),
    .cif(cif)
  );

  // Flag updates; a new event wins over a clear in the same cycle.
  assign next_cap_flag = cif.cap_evt
                      || (capture_flag && !(capture_irq_ack || capture_flag_clear));
  assign next_ovf_flag = (ovf_evt && !wr_cnt_lo)
                      || (overflow_flag && !(overflow_irq_ack || overflow_flag_clear));

  // Flags and their interrupt requests.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_flag <= 1'b0;
      capture_irq <= 1'b0;
      overflow_flag <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      capture_flag <= next_cap_flag; // see [R12] see [R13]
      capture_irq <= next_cap_flag && capture_irq_enable; // see [R13]
      overflow_flag <= next_ovf_flag; // see [R10]
      overflow_irq <= next_ovf_flag && overflow_irq_enable; // see [R10]
    end
  end

  a_stop_hold: assert property (@(posedge clk) disable iff (!rstn) // see [R1]
    clock_select_field == `TCC_CS_STOP && !wr_cnt_lo |=> $stable(count_value))
    else $error("Counter moved with no tick source selected.");

  a_cpu_load: assert property (@(posedge clk) disable iff (!rstn) // see [R7]
    wr_cnt_lo |=> count_value == {$past(hold_byte), $past(acc_wdata)})
    else $error("CPU write did not load the counter.");

  a_read_latch: assert property (@(posedge clk) disable iff (!rstn) // see [R5]
    acc_rd && acc_sel == tcc_sel_cnt_lo ##1 acc_rd && acc_sel == tcc_sel_cnt_hi
    |=> acc_rdata == $past(count_value[15:8], 2))
    else $error("High-byte read missed the latched counter byte.");

  a_cap_copy: assert property (@(posedge clk) disable iff (!rstn) // see [R11]
    cif.cap_evt |=> cap_reg == $past(count_value) && capture_flag)
    else $error("Capture did not store the counter and set the flag.");

  a_set_wins: assert property (@(posedge clk) disable iff (!rstn) // see [R13]
    cif.cap_evt && (capture_flag_clear || capture_irq_ack) |=> capture_flag)
    else $error("Capture event lost to a simultaneous clear.");

  a_cap_guard: assert property (@(posedge clk) disable iff (!rstn) // see [R15]
    !cap_top && !cif.cap_evt |=> $stable(cap_reg))
    else $error("Capture register written outside ceiling modes.");

  a_up_step: assert property (@(posedge clk) disable iff (!rstn) // see [R4]
    timer_tick && seq == tcc_seq_normal && !wr_cnt_lo
    |=> count_value == $past(count_value) + `TCC_CNT_STEP)
    else $error("Counter did not step by one on a tick.");

  a_ceil_clear: assert property (@(posedge clk) disable iff (!rstn) // see [R23]
    timer_tick && seq == tcc_seq_clear && count_value == ceil_val && !wr_cnt_lo
    |=> count_value == `TCC_FLOOR)
    else $error("Counter did not clear at the ceiling.");

  a_presc_reset: assert property (@(posedge clk) disable iff (!rstn) // see [R3]
    prescaler_reset |=> presc == `TCC_PRESC_RST
    ##1 presc == ($past(prescaler_reset) ? `TCC_PRESC_RST : `TCC_PRESC_STEP))
    else $error("Prescaler did not restart after its reset.");
endmodule

// ===== shared/tcc_cap_if.sv
// Interface between the timer core and its capture input filter.
`timescale 1ns/100ps
interface tcc_cap_if;
  logic raw_in;     // Selected trigger source level.
  logic filt_en;    // Noise canceler enable.
  logic rising_sel; // High picks rising edges, low picks falling edges.
  logic input_en;   // Edge detector input enable.
  logic cap_evt;    // One-cycle capture strobe.
  // Timer core side.
  modport core (output raw_in, output filt_en, output rising_sel,
                output input_en, input cap_evt);
  // Filter side.
  modport filt (input raw_in, input filt_en, input rising_sel,
                input input_en, output cap_evt);
endinterface

// ===== shared/tcc_consts.svh
// Constant macros for the sixteen-bit timer/counter: codes, masks, limits and reset values.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7
`define TCC_MASK_DIV8 10'h007
`define TCC_MASK_DIV64 10'h03F
`define TCC_MASK_DIV256 10'h0FF
`define TCC_MASK_DIV1024 10'h3FF
`define TCC_PRESC_RST 10'h000
`define TCC_PRESC_STEP 10'h001
`define TCC_TOP_8BIT 16'h00FF
`define TCC_TOP_9BIT 16'h01FF
`define TCC_TOP_10BIT 16'h03FF
`define TCC_MAX 16'hFFFF
`define TCC_FLOOR 16'h0000
`define TCC_CNT_STEP 16'h0001
`define TCC_CNT_RST 16'h0000
`define TCC_BYTE_RST 8'h00
`define TCC_WGM_PFC_CAP 4'h8
`define TCC_WGM_PC_CAP 4'hA
`define TCC_WGM_CTC_CAP 4'hC
`define TCC_WGM_FAST_CAP 4'hE
`define TCC_FILT_SAMPLES 4
`endif

// ===== shared/tcc_pkg.sv
// Type package for the sixteen-bit timer/counter.
package tcc_pkg;
  // Byte location addressed by the CPU access port.
  typedef enum logic [2:0] {
    tcc_sel_cnt_lo, tcc_sel_cnt_hi, tcc_sel_cap_lo,
    tcc_sel_cap_hi, tcc_sel_cmpa_lo, tcc_sel_cmpa_hi
  } tcc_sel_e;
  // Counting direction of the dual-slope sequences.
  typedef enum logic {tcc_dir_up, tcc_dir_down} tcc_dir_e;
  // Kind of counting sequence picked by the waveform mode.
  typedef enum logic [1:0] {
    tcc_seq_normal, tcc_seq_clear, tcc_seq_wrap, tcc_seq_dual
  } tcc_seq_e;
endpackage

// ===== verification/tb_top.sv
// Self-checking bench for the sixteen-bit timer/counter.
`timescale 1ns/100ps
module tb_top;
  import tcc_pkg::*;
  // Clock, reset and access port.
  logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
  tcc_sel_e sel = tcc_sel_cnt_lo;
  logic [7:0] wdata = 8'h00, rdata;
  // Control levels and pulses.
  logic [2:0] cs = 3'h0;
  logic [3:0] wgm = 4'h0;
  logic filt = 1'b0, rise = 1'b1, cmp_sel = 1'b0, cap_ie = 1'b0, ovf_ie = 1'b0;
  logic cap_clr = 1'b0, pin_req = 1'b0, cmp_req = 1'b0;
  // Inputs that idle low until a test drives them.
  logic ext_pin = 1'b0, ovf_ack = 1'b0, cap_ack = 1'b0, presc_rst = 1'b0, ovf_clr = 1'b0;
  // Observed outputs and event lines.
  logic [15:0] cnt;
  logic ceil_f, floor_f, cap_flag, cap_irq, ovf_flag, ovf_irq, pin, cmpo;
  int errors = 0, checks_done = 0, cycles = 0;

  // The clock toggles every half period of 4 ns.
  always #4 clk = ~clk;

  tcc_evt_src evt_u (.clk(clk), .pin_req(pin_req), .cmp_req(cmp_req),
    .capture_pin(pin), .comparator_output(cmpo));

  tcc_timer16 dut_u (.clk(clk), .rstn(rstn), .acc_sel(sel), .acc_rd(rd), .acc_wr(wr),
    .acc_wdata(wdata), .acc_rdata(rdata), .clock_select_field(cs),
    .waveform_mode_field(wgm), .prescaler_reset(presc_rst), .noise_filter_enable(filt),
    .edge_rising(rise), .comparator_capture_select(cmp_sel), .capture_irq_enable(cap_ie),
    .overflow_irq_enable(ovf_ie), .capture_irq_ack(cap_ack),
    .capture_flag_clear(cap_clr), .overflow_irq_ack(ovf_ack),
    .overflow_flag_clear(ovf_clr), .capture_pin(pin), .comparator_output(cmpo),
    .ext_count_pin(ext_pin), .count_value(cnt), .count_ceiling(ceil_f),
    .count_floor(floor_f), .capture_flag(cap_flag), .capture_irq(cap_irq),
    .overflow_flag(ovf_flag), .overflow_irq(ovf_irq), .presc_taps());

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hung run counts as a mismatch and closes the report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One byte access, held from a falling edge across one sampling edge.
  task automatic acc(input tcc_sel_e s, input logic w, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask

  // Sixteen-bit write, high byte first.
  task automatic wr16(input tcc_sel_e hi, input tcc_sel_e lo, input logic [15:0] v);
    acc(hi, 1'b1, v[15:8]);
    acc(lo, 1'b1, v[7:0]);
  endtask

  // Sixteen-bit read, low byte then high byte on back-to-back edges.
  task automatic rd16(input tcc_sel_e lo, input tcc_sel_e hi, output logic [15:0] v);
    @(negedge clk);
    sel = lo;
    rd = 1'b1;
    @(negedge clk);
    v[7:0] = rdata;
    sel = hi;
    @(negedge clk);
    v[15:8] = rdata;
    rd = 1'b0;
  endtask

  // Pulses the flag clear, or the interrupt acknowledge when a is high.
  task automatic clr_cap(input logic a);
    @(negedge clk);
    cap_clr = !a;
    cap_ack = a;
    @(negedge clk);
    cap_clr = 1'b0;
    cap_ack = 1'b0;
  endtask

  // Stopped counter: paired access and a lone high-byte write.
  task automatic t_access;
    logic [15:0] v;
    wr16(tcc_sel_cnt_hi, tcc_sel_cnt_lo, 16'h01FF);
    repeat (5) @(negedge clk);
    chk("count stopped", 16'h01FF, cnt);
    acc(tcc_sel_cnt_hi, 1'b1, 8'h77);
    chk("high write only", 16'h01FF, cnt);
    rd16(tcc_sel_cnt_lo, tcc_sel_cnt_hi, v);
    chk("count read", 16'h01FF, v);
    $display("test access done");
  endtask

  // Prescaler restart, first divide-by-8 tick, then one external edge.
  task automatic t_presc;
    wr16(tcc_sel_cnt_hi, tcc_sel_cnt_lo, 16'h0000);
    @(negedge clk);
    presc_rst = 1'b1;
    @(negedge clk);
    presc_rst = 1'b0;
    cs = 3'h2;
    repeat (7) @(negedge clk);
    chk("no early tick", 16'h0000, cnt);
    @(negedge clk);
    chk("first tick", 16'h0001, cnt);
    cs = 3'h7;
    ext_pin = 1'b1;
    repeat (2) @(negedge clk);
    chk("external edge", 16'h0002, cnt);
    cs = 3'h0;
    ext_pin = 1'b0;
    $display("test prescaler done");
  endtask

  // Running counter: step, write priority, wrap and overflow.
  task automatic t_count;
    logic [15:0] v;
    int n;
    cs = 3'h1;
    repeat (4) @(negedge clk);
    v = cnt;
    @(negedge clk);
    chk("count step", v + 16'h0001, cnt);
    wr16(tcc_sel_cnt_hi, tcc_sel_cnt_lo, 16'h1234);
    chk("write wins", 16'h1234, cnt);
    cs = 3'h0;
    wr16(tcc_sel_cnt_hi, tcc_sel_cnt_lo, 16'h00FD);
    wgm = 4'h5;
    ovf_ie = 1'b1;
    cs = 3'h1;
    n = 0;
    while (cnt !== 16'h0000 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("wrap at ceiling", 16'h0000, cnt);
    chk("ceiling flag", 16'h0001, {15'h0000, ceil_f});
    @(negedge clk);
    chk("floor flag", 16'h0001, {15'h0000, floor_f});
    chk("overflow flag", 16'h0001, {15'h0000, ovf_flag});
    chk("overflow irq", 16'h0001, {15'h0000, ovf_irq});
    ovf_clr = 1'b1;
    @(negedge clk);
    ovf_clr = 1'b0;
    chk("overflow cleared", 16'h0000, {15'h0000, ovf_flag});
    cs = 3'h0;
    wgm = 4'h0;
    $display("test count done");
  endtask

  // Sets the line idle, clears the flag, then gives the chosen edge.
  task automatic cap_try(input logic c, input logic r, input logic [15:0] val,
                         input logic e, output int lat);
    logic [15:0] v;
    cmp_sel = c;
    rise = r;
    wr16(tcc_sel_cnt_hi, tcc_sel_cnt_lo, val);
    if (c) cmp_req = !r;
    else pin_req = !r;
    repeat (12) @(negedge clk);
    clr_cap(1'b0);
    if (c) cmp_req = r;
    else pin_req = r;
    lat = 0;
    while (cap_flag !== 1'b1 && lat < 14) begin
      @(negedge clk);
      lat++;
    end
    chk("capture flag", {15'h0000, e}, {15'h0000, cap_flag});
    chk("capture irq", {15'h0000, e & cap_ie}, {15'h0000, cap_irq});
    if (e) begin
      rd16(tcc_sel_cap_lo, tcc_sel_cap_hi, v);
      chk("capture value", val, v);
    end
    clr_cap(1'b1);
    chk("flag cleared", 16'h0000, {15'h0000, cap_flag});
  endtask

  // Sources, edges and the noise canceler.
  task automatic t_capture;
    int l0, l1;
    cap_ie = 1'b1;
    cap_try(1'b0, 1'b1, 16'hA55A, 1'b1, l0);
    cap_try(1'b1, 1'b0, 16'h5AA5, 1'b1, l1);
    cap_try(1'b0, 1'b0, 16'h0F0F, 1'b1, l1);
    filt = 1'b1;
    @(negedge clk);
    pin_req = 1'b1;
    repeat (3) @(negedge clk);
    pin_req = 1'b0;
    repeat (14) @(negedge clk);
    chk("glitch ignored", 16'h0000, {15'h0000, cap_flag});
    cap_try(1'b0, 1'b1, 16'h3C3C, 1'b1, l1);
    chk("filter delay", 16'h0004, 16'(l1 - l0));
    filt = 1'b0;
    $display("test capture done");
  endtask

  // Capture register writes by mode, and the input gated off.
  task automatic t_capmode;
    logic [15:0] v;
    int l;
    wr16(tcc_sel_cap_hi, tcc_sel_cap_lo, 16'h1111);
    rd16(tcc_sel_cap_lo, tcc_sel_cap_hi, v);
    chk("write refused", 16'h3C3C, v);
    wgm = 4'hE;
    wr16(tcc_sel_cap_hi, tcc_sel_cap_lo, 16'h2222);
    rd16(tcc_sel_cap_lo, tcc_sel_cap_hi, v);
    chk("write taken", 16'h2222, v);
    cap_try(1'b0, 1'b1, 16'h0010, 1'b0, l);
    rd16(tcc_sel_cap_lo, tcc_sel_cap_hi, v);
    chk("ceiling kept", 16'h2222, v);
    $display("test capture mode done");
  endtask

  // Reset for 20 cycles, then the tests in turn.
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_access();
    t_presc();
    t_count();
    t_capture();
    t_capmode();
    test_done();
  end
endmodule

// ===== verification/tcc_evt_src.sv
// Far-side model that drives the capture pin and the comparator output.
`timescale 1ns/100ps
module tcc_evt_src (
  // Clock.
  input wire logic clk,
  // Levels asked for by the bench.
  input wire logic pin_req,
  input wire logic cmp_req,
  // Event lines toward the timer.
  output logic capture_pin,
  output logic comparator_output
);
  // Both lines start low so the timer never samples an unknown.
  initial begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
  end
  // Levels move by a non-blocking update on the rising edge, so the timer
  // sees each change exactly one edge later and never races the bench.
  always @(posedge clk) begin
    capture_pin <= pin_req;
    comparator_output <= cmp_req;
  end
endmodule
